//--- mdt_dev_calc.sv
`timescale 1ns/1ps
// Deviation in units of crystal/2^17: implied-one mantissa shifted by exponent
module mdt_dev_calc (
	mdt_dev_if.calc dif,
	input wire logic clk,
	input wire logic reset
);
	logic [mdt_pkg::DEV_W-1:0] base;

	// Three-bit mantissa with the leading one implied, i.e. eight plus mantissa
	always_comb begin
		base = {{(mdt_pkg::DEV_W-mdt_pkg::MANT_W-1){1'b0}}, 1'b1, dif.mantissa};
		dif.dev_step = base << dif.exponent;
	end

	AST_DEV_SCALE: assert property (@(posedge clk) disable iff (reset)
		dif.dev_step == ((mdt_pkg::DEV_W'(8) + mdt_pkg::DEV_W'(dif.mantissa)) * (mdt_pkg::DEV_W'(1) << dif.exponent)))
		else $error("deviation step does not match eight plus mantissa times two to the exponent");
endmodule : mdt_dev_calc

//--- mdt_dev_if.sv
`timescale 1ns/1ps
// Carries the deviation fields to the calculator and the scaled step back
interface mdt_dev_if;
	logic [mdt_pkg::EXP_W-1:0] exponent;
	logic [mdt_pkg::MANT_W-1:0] mantissa;
	logic [mdt_pkg::DEV_W-1:0] dev_step;
	modport cfg (output exponent, output mantissa, input dev_step);
	modport calc (input exponent, input mantissa, output dev_step);
endinterface : mdt_dev_if

//--- mdt_host_model.sv
`timescale 1ns/1ps
// Host side of the register port: one request per call, moved just after an edge
module mdt_host_model (
	input wire logic clk,
	output logic [5:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	input wire logic [7:0] reg_rdata
);
	// Idle port at time zero
	initial begin
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		reg_we = 1'b0;
	end
	// Strobe held for exactly one edge, since a held strobe writes again
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		@(posedge clk) #1;
		reg_we = 1'b0;
		reg_wdata = ~d; // Stale data shows a changed pattern
	endtask : wr
	// Address taken at one edge, data stands after it
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		reg_addr = a;
		@(posedge clk) #1;
		d = reg_rdata;
	endtask : rd
endmodule : mdt_host_model

//--- mdt_modem_dev_rx.sv
`timescale 1ns/1ps
// Notes on behaviour
// - FSK receive uses the programmed deviation as the expected incoming deviation.
// - OOK selected: deviation exponent and mantissa ignored for receive and transmit.
// - FSK transmit shifts carrier down by deviation for zero, up for one.
// - Deviation equals crystal over 2^17 times (8 + mantissa) times 2^exponent.
// - Early-end bit set: receive ends on carrier sense, not normal timeout.
// - Early end with OOK: timeout if no carrier sense in first eight symbols.
module mdt_modem_dev_rx #(
	parameter int CS_WINDOW = mdt_pkg::OOK_CS_SYMBOLS // Symbols allowed for carrier sense in OOK
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	output logic [7:0] reg_rdata,
	input wire logic [2:0] mod_format,
	input wire logic tx_symbol_bit,
	input wire logic rx_active,
	input wire logic symbol_tick,
	input wire logic carrier_sense,
	input wire logic rx_timeout,
	output logic [mdt_pkg::DEV_W-1:0] rx_expected_dev,
	output logic signed [mdt_pkg::DEV_W:0] tx_freq_offset,
	output logic rx_end,
	output logic [3:0] tune_bits
);
	logic [7:0] dev_setting_r;
	logic [7:0] radio_cfg_two_r;
	logic [7:0] reg_rdata_r;
	logic [mdt_pkg::DEV_W-1:0] rx_expected_dev_r;
	logic signed [mdt_pkg::DEV_W:0] tx_freq_offset_r;
	logic rx_end_r;
	logic [3:0] sym_cnt_r;
	logic cs_seen_r;
	logic is_ook;
	logic early_en;
	logic signed [mdt_pkg::DEV_W:0] dev_signed;

	mdt_dev_if dif ();

	// Symbol counter is four bits wide, so the window must fit inside it
	if (CS_WINDOW < 1 || CS_WINDOW > 15) begin : g_bad_window
		$error("carrier-sense window does not fit the symbol counter");
	end

	// Mapped-address decode used by the read-data process
	function automatic logic read_mask_ok(input logic [5:0] a);
		read_mask_ok = (a == mdt_pkg::DEV_SETTING_ADDR) || (a == mdt_pkg::RADIO_CFG_TWO_ADDR);
	endfunction : read_mask_ok

	assign is_ook = (mod_format == mdt_pkg::MDT_MOD_OOK);
	assign early_en = radio_cfg_two_r[mdt_pkg::EARLY_END_BIT];
	assign dif.exponent = dev_setting_r[mdt_pkg::DEV_EXP_LSB +: mdt_pkg::EXP_W];
	assign dif.mantissa = dev_setting_r[mdt_pkg::DEV_MANT_LSB +: mdt_pkg::MANT_W];
	assign dev_signed = {1'b0, dif.dev_step};
	assign tune_bits = radio_cfg_two_r[mdt_pkg::TUNE_LSB +: 4];
	assign reg_rdata = reg_rdata_r;
	assign rx_expected_dev = rx_expected_dev_r;
	assign tx_freq_offset = tx_freq_offset_r;
	assign rx_end = rx_end_r;

	mdt_dev_calc u_calc (
		.dif(dif),
		.clk(clk),
		.reset(reset)
	);

	// Register writes; masking keeps unused bits at zero so reads need no extra gating
	always_ff @(posedge clk) begin
		if (reset) begin
			dev_setting_r <= mdt_pkg::DEV_SETTING_RESET;
			radio_cfg_two_r <= mdt_pkg::RADIO_CFG_TWO_RESET;
		end else if (reg_we) begin
			if (reg_addr == mdt_pkg::DEV_SETTING_ADDR) begin
				dev_setting_r <= reg_wdata & mdt_pkg::DEV_SETTING_MASK;
			end
			if (reg_addr == mdt_pkg::RADIO_CFG_TWO_ADDR) begin
				radio_cfg_two_r <= reg_wdata & mdt_pkg::RADIO_CFG_TWO_MASK;
			end
		end
	end

	// Read data, one cycle after the address; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata_r <= 8'h00;
		end else if (!read_mask_ok(reg_addr)) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_addr == mdt_pkg::DEV_SETTING_ADDR) begin
			reg_rdata_r <= dev_setting_r;
		end else begin
			reg_rdata_r <= radio_cfg_two_r;
		end
	end

	// Demodulator expects the programmed deviation; OOK has no deviation at all
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_expected_dev_r <= '0;
		end else if (is_ook) begin
			rx_expected_dev_r <= '0;
		end else begin
			rx_expected_dev_r <= dif.dev_step;
		end
	end

	// Transmit offset: minus for a zero bit, plus for a one bit
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_freq_offset_r <= '0;
		end else if (is_ook) begin
			tx_freq_offset_r <= '0;
		end else if (tx_symbol_bit) begin
			tx_freq_offset_r <= dev_signed;
		end else begin
			tx_freq_offset_r <= -dev_signed;
		end
	end

	// OOK window: counts symbols up to the window length; cleared between receptions
	always_ff @(posedge clk) begin
		if (reset || !rx_active) begin
			sym_cnt_r <= '0;
			cs_seen_r <= 1'b0;
		end else begin
			if (carrier_sense) begin
				cs_seen_r <= 1'b1;
			end
			if (symbol_tick && sym_cnt_r < 4'(CS_WINDOW)) begin
				sym_cnt_r <= sym_cnt_r + 4'h1;
			end
		end
	end

	// Receive end pulse; early termination replaces the normal timeout when enabled
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_end_r <= 1'b0;
		end else if (!rx_active || rx_end_r) begin
			rx_end_r <= 1'b0;
		end else if (!early_en) begin
			rx_end_r <= rx_timeout;
		end else if (is_ook) begin
			rx_end_r <= !cs_seen_r && !carrier_sense && symbol_tick
				&& sym_cnt_r == 4'(CS_WINDOW - 1);
		end else begin
			rx_end_r <= symbol_tick && !carrier_sense;
		end
	end

	AST_RX_DEV_FSK: assert property (@(posedge clk) disable iff (reset)
		!is_ook |=> rx_expected_dev == $past(dif.dev_step))
		else $error("expected receive deviation differs from programmed value");

	AST_OOK_IGNORES_DEV: assert property (@(posedge clk) disable iff (reset)
		is_ook |=> (rx_expected_dev == '0) && (tx_freq_offset == '0))
		else $error("deviation used while OOK is selected");

	AST_TX_SHIFT_SIGN: assert property (@(posedge clk) disable iff (reset)
		(!is_ook && !tx_symbol_bit) |=> tx_freq_offset == -$past(dev_signed))
		else $error("zero bit not shifted downward by deviation");

	AST_EARLY_END_CS: assert property (@(posedge clk) disable iff (reset)
		(rx_active && early_en && !is_ook && symbol_tick && !carrier_sense && !rx_end) |=> rx_end)
		else $error("receive did not end on missing carrier sense");

	AST_NO_TIMEOUT_EARLY: assert property (@(posedge clk) disable iff (reset)
		(early_en && rx_timeout && !is_ook && !symbol_tick) |=> !rx_end)
		else $error("normal timeout ended receive while early end enabled");

	AST_OOK_EIGHT_SYMBOLS: assert property (@(posedge clk) disable iff (reset)
		(rx_end && early_en && is_ook) |-> $past(sym_cnt_r) == 4'(CS_WINDOW - 1) && !$past(cs_seen_r))
		else $error("OOK receive ended outside the eighth symbol without carrier");

	AST_UNUSED_READ_ZERO: assert property (@(posedge clk) disable iff (reset)
		($past(reg_addr) == mdt_pkg::DEV_SETTING_ADDR) |-> (reg_rdata[7] == 1'b0) && (reg_rdata[3] == 1'b0))
		else $error("unused deviation register bit reads nonzero");

	AST_UNUSED_CFG_ZERO: assert property (@(posedge clk) disable iff (reset)
		($past(reg_addr) == mdt_pkg::RADIO_CFG_TWO_ADDR) |-> reg_rdata[7:5] == 3'h0)
		else $error("unused control register bits read nonzero");

	// Stored values never carry unused bits, whatever the host wrote
	AST_DEV_REG_UNUSED: assert property (@(posedge clk) disable iff (reset)
		(dev_setting_r & ~mdt_pkg::DEV_SETTING_MASK) == 8'h00)
		else $error("unused deviation register bit stored as one");

	AST_CFG_REG_UNUSED: assert property (@(posedge clk) disable iff (reset)
		(radio_cfg_two_r & ~mdt_pkg::RADIO_CFG_TWO_MASK) == 8'h00)
		else $error("unused control register bit stored as one");

	// Read data shows the register as it stood at the address edge, so a same-cycle write is not seen yet
	AST_READ_DEV_VALUE: assert property (@(posedge clk) disable iff (reset)
		(!$past(reset) && $past(reg_addr) == mdt_pkg::DEV_SETTING_ADDR)
		|-> reg_rdata == $past(dev_setting_r))
		else $error("deviation register read back a different value");

	AST_READ_CFG_VALUE: assert property (@(posedge clk) disable iff (reset)
		(!$past(reset) && $past(reg_addr) == mdt_pkg::RADIO_CFG_TWO_ADDR)
		|-> reg_rdata == $past(radio_cfg_two_r))
		else $error("control register read back a different value");

	// One bit shifts upward by the full deviation
	AST_TX_SHIFT_ONE: assert property (@(posedge clk) disable iff (reset)
		(!is_ook && tx_symbol_bit) |=> tx_freq_offset == $past(dev_signed))
		else $error("one bit not shifted upward by deviation");

	// Receive end with early termination off, then on
	AST_NORMAL_TIMEOUT: assert property (@(posedge clk) disable iff (reset)
		(rx_active && !early_en && rx_timeout && !rx_end) |=> rx_end)
		else $error("normal timeout did not end receive");

	AST_FSK_CS_HOLDS: assert property (@(posedge clk) disable iff (reset)
		(rx_active && early_en && !is_ook && carrier_sense) |=> !rx_end)
		else $error("receive ended although carrier sense was present");

	AST_RX_END_PULSE: assert property (@(posedge clk) disable iff (reset)
		rx_end |=> !rx_end)
		else $error("receive end stood longer than one cycle");

	AST_OOK_CS_KEEPS_RX: assert property (@(posedge clk) disable iff (reset)
		(early_en && is_ook && (cs_seen_r || carrier_sense)) |=> !rx_end)
		else $error("OOK receive ended after carrier sense was seen");

	AST_OOK_COUNT_BOUND: assert property (@(posedge clk) disable iff (reset)
		sym_cnt_r <= 4'(CS_WINDOW))
		else $error("OOK symbol counter ran past the window");
endmodule : mdt_modem_dev_rx

//--- mdt_modem_dev_rx_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module mdt_modem_dev_rx_tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [5:0] addr;
	logic [7:0] wdata, rdata, v;
	logic we, rx_end;
	logic [2:0] mod = 3'h0;
	logic tx_bit = 1'b1, rx_act = 1'b0, tick = 1'b0, cs = 1'b0, tmo = 1'b0;
	logic [3:0] tune;
	logic [mdt_pkg::DEV_W-1:0] dev;
	logic signed [mdt_pkg::DEV_W:0] offs;
	int n_errors = 0;
	int comparisons = 0;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	mdt_host_model host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_we(we), .reg_rdata(rdata));
	mdt_modem_dev_rx DUT (.clk(clk), .reset(reset), .reg_addr(addr), .reg_wdata(wdata), .reg_we(we),
		.reg_rdata(rdata), .mod_format(mod), .tx_symbol_bit(tx_bit), .rx_active(rx_act),
		.symbol_tick(tick), .carrier_sense(cs), .rx_timeout(tmo), .rx_expected_dev(dev),
		.tx_freq_offset(offs), .rx_end(rx_end), .tune_bits(tune));
	// Inputs move 1 ns after an edge, never on it
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// Both deviation outputs, the transmit offset for both symbol values
	task automatic dev_chk(input logic [mdt_pkg::DEV_W-1:0] e);
		tx_bit = 1'b1;
		step(3);
		`CHK("rx_expected_dev", e, dev)
		`CHK("tx_offset_one", {1'b0, e}, offs)
		tx_bit = 1'b0;
		step(2);
		`CHK("tx_offset_zero", -{1'b0, e}, offs)
	endtask : dev_chk
	// Reset contents and the deviation they give
	task automatic t_reset;
		host.rd(6'h15, v);
		`CHK("dev_setting", 8'h47, v)
		host.rd(6'h16, v);
		`CHK("cfg_two", 8'h07, v)
		dev_chk(11'h0F0);
	endtask : t_reset
	// Unused bits, an unmapped place, and the formula at both extremes
	task automatic t_fields;
		host.wr(6'h15, 8'hFF);
		host.wr(6'h20, 8'hFF);
		host.rd(6'h15, v);
		`CHK("dev_setting", 8'h77, v)
		host.rd(6'h20, v);
		`CHK("unmapped", 8'h00, v)
		dev_chk(11'h780);
		host.wr(6'h15, 8'h00);
		dev_chk(11'h008);
		host.wr(6'h16, 8'hEA);
		host.rd(6'h16, v);
		`CHK("cfg_two", 8'h0A, v)
		`CHK("tune_bits", 4'hA, tune)
	endtask : t_fields
	// Every format: OOK drops the deviation, the FSK kinds keep it
	task automatic t_modes;
		logic [2:0] m [4] = '{3'h0, 3'h1, 3'h4, 3'h3};
		foreach (m[i]) begin
			mod = m[i];
			dev_chk(m[i] == 3'h3 ? 11'h000 : 11'h008);
		end
	endtask : t_modes
	// One event cycle; rx_end only stands one cycle, so it is looked at then
	task automatic sym(input logic t, input logic c, input logic o, input logic e);
		tick = t;
		cs = c;
		tmo = o;
		step(1);
		{tick, cs, tmo} = 3'h0;
		`CHK("rx_end", e, rx_end)
		step(1);
	endtask : sym
	// Normal timeout, FSK early end, and the OOK eight-symbol window
	task automatic t_end;
		mod = 3'h0;
		rx_act = 1'b1;
		host.wr(6'h16, 8'h07);
		sym(1'b1, 1'b0, 1'b0, 1'b0);
		sym(1'b0, 1'b0, 1'b1, 1'b1);
		host.wr(6'h16, 8'h17);
		sym(1'b0, 1'b0, 1'b1, 1'b0);
		sym(1'b1, 1'b1, 1'b0, 1'b0);
		sym(1'b1, 1'b0, 1'b0, 1'b1);
		mod = 3'h3;
		for (int k = 0; k < 2; k++) begin
			rx_act = 1'b0;
			step(2);
			rx_act = 1'b1;
			step(1);
			sym(1'b1, k[0], 1'b0, 1'b0);
			repeat (6) sym(1'b1, 1'b0, 1'b0, 1'b0);
			sym(1'b1, 1'b0, 1'b0, !k[0]);
			sym(1'b1, 1'b0, 1'b0, 1'b0);
		end
	endtask : t_end
	task automatic stop_test;
		$display("Mismatches %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	// Main sequence after ten cycles of reset
	initial begin
		step(10);
		reset = 1'b0;
		t_reset();
		t_fields();
		t_modes();
		t_end();
		stop_test();
	end
	// Watchdog: the run needs about 120 cycles, so 4000 means a hang
	initial begin
		#20000;
		n_errors++;
		stop_test();
	end
endmodule : mdt_modem_dev_rx_tb

//--- mdt_pkg.sv
package mdt_pkg;
	// Register offsets on the serial register port
	localparam logic [5:0] DEV_SETTING_ADDR = 6'h15;
	localparam logic [5:0] RADIO_CFG_TWO_ADDR = 6'h16;
	// Reset values
	localparam logic [7:0] DEV_SETTING_RESET = 8'h47;
	localparam logic [7:0] RADIO_CFG_TWO_RESET = 8'h07;
	// Field positions in the deviation register
	localparam int DEV_EXP_LSB = 4;
	localparam int DEV_MANT_LSB = 0;
	localparam logic [7:0] DEV_SETTING_MASK = 8'h77;
	// Field positions in the radio control register
	localparam int EARLY_END_BIT = 4;
	localparam int TUNE_LSB = 0;
	localparam logic [7:0] RADIO_CFG_TWO_MASK = 8'h1F;
	// Field widths and derived deviation width
	localparam int EXP_W = 3;
	localparam int MANT_W = 3;
	localparam int DEV_W = MANT_W + 1 + (1 << EXP_W) - 1;
	// OOK carrier-sense window in symbol periods
	localparam int OOK_CS_SYMBOLS = 8;
	// Modulation formats
	typedef enum logic [2:0] {
		MDT_MOD_2FSK = 3'b000,
		MDT_MOD_GFSK = 3'b001,
		MDT_MOD_OOK = 3'b011,
		MDT_MOD_4FSK = 3'b100
	} mdt_mod_e;
endpackage : mdt_pkg
